// file: hmp_pkg.sv
// constants and types shared by the host mailbox port files
package hmp_pkg;

   // ---------------------------------------------------------------
   // port count and data width
   // ---------------------------------------------------------------
   localparam int unsigned HMP_NPORT = 3;    // keyboard, power one, power two
   localparam int unsigned HMP_DW    = 8;    // every register is one byte

   // ---------------------------------------------------------------
   // microcontroller register addresses, indexed by port
   // ---------------------------------------------------------------
   localparam logic [7:0] HMP_STAT_ADDR [HMP_NPORT] = '{8'hAD, 8'hBD, 8'hF5};
   localparam logic [7:0] HMP_IN_ADDR   [HMP_NPORT] = '{8'hAE, 8'hBE, 8'hF6};
   localparam logic [7:0] HMP_OUT_ADDR  [HMP_NPORT] = '{8'hAF, 8'hBF, 8'hF7};

   // ---------------------------------------------------------------
   // status register layout
   // ---------------------------------------------------------------
   localparam int unsigned HMP_OBF_BIT = 0;  // output buffer full
   localparam int unsigned HMP_IBF_BIT = 1;  // input buffer full
   localparam int unsigned HMP_CMD_BIT = 3;  // last host write was a command
   localparam logic [7:0]  HMP_USER_MASK = 8'hF4;   // bits 7..4 and 2
   localparam logic [7:0]  HMP_RD_IDLE   = 8'h00;   // answer to unmapped reads

   // ---------------------------------------------------------------
   // host select decode result
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      HMP_SEL_KBD  = 2'b00,
      HMP_SEL_PM1  = 2'b01,
      HMP_SEL_PM2  = 2'b10,
      HMP_SEL_NONE = 2'b11
   } hmp_sel_t;

endpackage

// file: hmp_strobe.sv
// falling-edge detector for an active-low host strobe
`timescale 1ns/10ps
`default_nettype none
module hmp_strobe
   import hmp_pkg::*;
(
   input  wire logic sys_clk,     // core clock
   input  wire logic rst,         // synchronous reset, active high
   input  wire logic strobe_n,    // host strobe, active low
   output logic      start        // one-cycle pulse on first low cycle
);

   // ---------------------------------------------------------------
   // previous level, reset low so a strobe held over reset is not taken
   // ---------------------------------------------------------------
   logic prev_q;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= strobe_n;
      end
   end

   // a strobe already low at reset release waits for its next edge
   assign start = prev_q & ~strobe_n;

endmodule
`default_nettype wire

// file: hmp_port.sv
// one mailbox port: input/output data bytes and status byte
`timescale 1ns/10ps
`default_nettype none
module hmp_port
   import hmp_pkg::*;
(
   input  wire logic              sys_clk,      // core clock
   input  wire logic              rst,          // synchronous reset
   input  wire logic              host_wr,      // host write taken
   input  wire logic              host_rd_out,  // host read of output data
   input  wire logic              host_a0,      // address bit at the write
   input  wire logic [HMP_DW-1:0] host_wdata,   // host byte
   input  wire logic              mc_wr_stat,   // core write of status
   input  wire logic              mc_wr_out,    // core write of output data
   input  wire logic              mc_rd_in,     // core read of input data
   input  wire logic [HMP_DW-1:0] mc_wdata,     // core byte
   output logic [HMP_DW-1:0]      status,       // status byte
   output logic [HMP_DW-1:0]      in_data,      // input data byte
   output logic [HMP_DW-1:0]      out_data      // output data byte
);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [HMP_DW-1:0] in_q;     // host-written byte, never reset
   logic [HMP_DW-1:0] out_q;    // core-written byte, never reset
   logic [HMP_DW-1:0] user_q;   // user status bits, never reset
   logic              cmd_q;    // command/data flag, never reset
   logic              ibf_q;    // input buffer full
   logic              obf_q;    // output buffer full

   // data bytes keep their contents through reset, so no reset branch
   always_ff @(posedge sys_clk) begin
      if (host_wr) begin
         in_q  <= host_wdata;
         cmd_q <= host_a0;
      end
      if (mc_wr_out) begin
         out_q <= mc_wdata;
      end
      if (mc_wr_stat) begin
         user_q <= mc_wdata & HMP_USER_MASK;
      end
   end

   // flags: reset wins, then a set wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ibf_q <= 1'b0;
         obf_q <= 1'b0;
      end else begin
         ibf_q <= host_wr   | (ibf_q & ~mc_rd_in);
         obf_q <= mc_wr_out | (obf_q & ~host_rd_out);
      end
   end

   // ---------------------------------------------------------------
   // read views
   // ---------------------------------------------------------------
   logic [HMP_DW-1:0] flags;    // flag bits placed in the byte
   always_comb begin
      flags = '0;
      flags[HMP_CMD_BIT] = cmd_q;
      flags[HMP_IBF_BIT] = ibf_q;
      flags[HMP_OBF_BIT] = obf_q;
   end
   assign status   = (user_q & HMP_USER_MASK) | flags;
   assign in_data  = in_q;
   assign out_data = out_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_ibf_set_write: assert property (@(posedge sys_clk) disable iff (rst)
      host_wr |=> status[HMP_IBF_BIT])
      else $error("input full not set by host write");
   a_ibf_clear_read: assert property (@(posedge sys_clk) disable iff (rst)
      mc_rd_in && !host_wr |=> !status[HMP_IBF_BIT])
      else $error("input full not cleared by core read");
   a_cmd_follows_a0: assert property (@(posedge sys_clk) disable iff (rst)
      host_wr |=> status[HMP_CMD_BIT] == $past(host_a0) && in_data == $past(host_wdata))
      else $error("command flag or data wrong after host write");
   a_cmd_flag_hold: assert property (@(posedge sys_clk)
      !host_wr |=> $stable(status[HMP_CMD_BIT]) && $stable(in_data))
      else $error("command flag or input data moved without host write");
   a_obf_handshake: assert property (@(posedge sys_clk) disable iff (rst)
      mc_wr_out |=> (status[HMP_OBF_BIT] and (!host_rd_out |=> status[HMP_OBF_BIT])))
      else $error("output full not set or lost early");
   a_flags_reset: assert property (@(posedge sys_clk)
      rst |=> status[HMP_IBF_BIT:HMP_OBF_BIT] == 2'b00)
      else $error("flags not cleared by reset");
   a_user_bits_keep: assert property (@(posedge sys_clk)
      !mc_wr_stat |=> $stable(status & HMP_USER_MASK))
      else $error("user status bits moved without core write");

endmodule
`default_nettype wire

// file: hmp_top.sv
// three host mailbox ports between a host bus and the core's registers
//
// Operation
// - host selects one port; all high ignored
// - host read: a0 low data, high status
// - host write loads input byte, a0 sets flag
// - status bit 3: 0 data, 1 command
// - command flag read-only, survives every reset
// - each port: input, output, status registers
// - input byte host-written, core read only
// - input bytes unchanged by reset
// - host write sets input-full flag
// - core read of input clears input-full
// - reset clears two low flags only
// - input-full and enable raise core interrupt
// - user status bits core-writable, survive reset
// - core writes status user bits, output byte
// - core write sets, host data read clears output-full
// - output-full drives host interrupt pins
// - no core interrupt from output-full
// - output byte core read/write, not reset
`timescale 1ns/10ps
`default_nettype none
module hmp_top
   import hmp_pkg::*;
(
   input  wire logic              sys_clk,                  // core clock, 40 MHz
   input  wire logic              rst,                      // synchronous reset
   // host bus side, sampled on sys_clk
   input  wire logic              kbd_port_select_n,        // keyboard port select
   input  wire logic              power_port_one_select_n,  // power port one select
   input  wire logic              power_port_two_select_n,  // power port two select
   input  wire logic              host_addr_bit_zero,       // data/status or data/command
   input  wire logic              host_rd_n,                // host read strobe
   input  wire logic              host_wr_n,                // host write strobe
   input  wire logic [HMP_DW-1:0] host_data_in,             // host data bus in
   output logic [HMP_DW-1:0]      host_data_out,            // host data bus out
   output logic                   host_data_oe,             // high while driving bus
   output logic                   host_kbd_irq_pin,         // active high
   output logic                   host_power_one_irq_n,     // active low
   output logic                   host_power_two_irq_n,     // active low
   // core register side
   input  wire logic [7:0]        sfr_addr,                 // register address
   input  wire logic              sfr_wr,                   // write strobe
   input  wire logic              sfr_rd,                   // read strobe
   input  wire logic [HMP_DW-1:0] sfr_wdata,                // write byte
   output logic [HMP_DW-1:0]      sfr_rdata,                // read byte, next cycle
   // core interrupt side
   input  wire logic              kbd_buf_irq_en,           // keyboard enable
   input  wire logic              power_one_buf_irq_en,     // power one enable
   input  wire logic              power_two_buf_irq_en,     // power two enable
   output logic                   kbd_buf_irq,              // keyboard request
   output logic                   power_one_buf_irq,        // power one request
   output logic                   power_two_buf_irq         // power two request
);

   // ---------------------------------------------------------------
   // host select decode
   // ---------------------------------------------------------------
   // more than one select low is the host's fault; we then take none,
   // which keeps the bus quiet instead of fighting over the read mux
   hmp_sel_t sel;          // decoded port
   wire [2:0] sel_n_vec = {power_port_two_select_n, power_port_one_select_n, kbd_port_select_n};

   always_comb begin
      case (sel_n_vec)
         3'b110:  sel = HMP_SEL_KBD;
         3'b101:  sel = HMP_SEL_PM1;
         3'b011:  sel = HMP_SEL_PM2;
         default: sel = HMP_SEL_NONE;
      endcase
   end

   wire sel_valid = (sel != HMP_SEL_NONE);   // one port addressed

   // ---------------------------------------------------------------
   // strobe edges
   // ---------------------------------------------------------------
   // each strobe acts once, on its first low cycle, so a long host
   // cycle cannot load or clear twice
   logic rd_start;         // read strobe went low
   logic wr_start;         // write strobe went low

   hmp_strobe u_rd_edge (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .strobe_n (host_rd_n),
      .start    (rd_start)
   );

   hmp_strobe u_wr_edge (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .strobe_n (host_wr_n),
      .start    (wr_start)
   );

   wire rd_go = rd_start & sel_valid;
   wire wr_go = wr_start & sel_valid;

   // ---------------------------------------------------------------
   // per-port views
   // ---------------------------------------------------------------
   logic [HMP_DW-1:0] stat_v [HMP_NPORT];   // status bytes
   logic [HMP_DW-1:0] in_v   [HMP_NPORT];   // input bytes
   logic [HMP_DW-1:0] out_v  [HMP_NPORT];   // output bytes
   logic [HMP_NPORT-1:0] port_hit;          // host addresses port i
   logic [HMP_NPORT-1:0] mc_stat_hit;       // core addresses status i
   logic [HMP_NPORT-1:0] mc_in_hit;         // core addresses input i
   logic [HMP_NPORT-1:0] mc_out_hit;        // core addresses output i

   // ---------------------------------------------------------------
   // ports, one instance each
   // ---------------------------------------------------------------
   for (genvar i = 0; i < HMP_NPORT; i++) begin : g_port
      assign port_hit[i]    = sel_valid && (sel == hmp_sel_t'(i));
      assign mc_stat_hit[i] = (sfr_addr == HMP_STAT_ADDR[i]);
      assign mc_in_hit[i]   = (sfr_addr == HMP_IN_ADDR[i]);
      assign mc_out_hit[i]  = (sfr_addr == HMP_OUT_ADDR[i]);

      // writes to the input address fall through unused: read only
      hmp_port u_port (
         .sys_clk     (sys_clk),
         .rst         (rst),
         .host_wr     (wr_go & port_hit[i]),
         .host_rd_out (rd_go & port_hit[i] & ~host_addr_bit_zero),
         .host_a0     (host_addr_bit_zero),
         .host_wdata  (host_data_in),
         .mc_wr_stat  (sfr_wr & mc_stat_hit[i]),
         .mc_wr_out   (sfr_wr & mc_out_hit[i]),
         .mc_rd_in    (sfr_rd & mc_in_hit[i]),
         .mc_wdata    (sfr_wdata),
         .status      (stat_v[i]),
         .in_data     (in_v[i]),
         .out_data    (out_v[i])
      );
   end

   // ---------------------------------------------------------------
   // host read path
   // ---------------------------------------------------------------
   // the byte is captured at the strobe edge so the host sees one value
   // for the whole read, even if the core writes meanwhile
   logic [HMP_DW-1:0] host_rd_mux;    // byte the host would read now
   always_comb begin
      host_rd_mux = HMP_RD_IDLE;
      for (int i = 0; i < HMP_NPORT; i++) begin
         if (port_hit[i]) begin
            host_rd_mux = host_addr_bit_zero ? stat_v[i] : out_v[i];
         end
      end
   end

   logic [HMP_DW-1:0] host_dout_q;    // held read byte
   logic              host_oe_q;      // bus drive enable

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         host_dout_q <= HMP_RD_IDLE;
      end else if (rd_go) begin
         host_dout_q <= host_rd_mux;
      end
   end

   // drive ends as soon as the strobe or the select goes away
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         host_oe_q <= 1'b0;
      end else if (host_rd_n || !sel_valid) begin
         host_oe_q <= 1'b0;
      end else if (rd_go) begin
         host_oe_q <= 1'b1;
      end
   end

   assign host_data_out = host_dout_q;
   assign host_data_oe  = host_oe_q;

   // ---------------------------------------------------------------
   // core register read path
   // ---------------------------------------------------------------
   // unmapped addresses answer zero; input writes by the core are dropped
   logic [HMP_DW-1:0] sfr_rd_mux;     // byte at sfr_addr
   always_comb begin
      sfr_rd_mux = HMP_RD_IDLE;
      for (int i = 0; i < HMP_NPORT; i++) begin
         if (mc_stat_hit[i]) begin
            sfr_rd_mux = stat_v[i];
         end else if (mc_in_hit[i]) begin
            sfr_rd_mux = in_v[i];
         end else if (mc_out_hit[i]) begin
            sfr_rd_mux = out_v[i];
         end
      end
   end

   logic [HMP_DW-1:0] sfr_rdata_q;    // registered read byte
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sfr_rdata_q <= HMP_RD_IDLE;
      end else if (sfr_rd) begin
         sfr_rdata_q <= sfr_rd_mux;
      end
   end
   assign sfr_rdata = sfr_rdata_q;

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   // core requests come only from input-full; output-full goes to the host
   assign kbd_buf_irq       = stat_v[0][HMP_IBF_BIT] & kbd_buf_irq_en;
   assign power_one_buf_irq = stat_v[1][HMP_IBF_BIT] & power_one_buf_irq_en;
   assign power_two_buf_irq = stat_v[2][HMP_IBF_BIT] & power_two_buf_irq_en;

   assign host_kbd_irq_pin     =  stat_v[0][HMP_OBF_BIT];
   assign host_power_one_irq_n = ~stat_v[1][HMP_OBF_BIT];
   assign host_power_two_irq_n = ~stat_v[2][HMP_OBF_BIT];

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_idle_bus_ignored: assert property (@(posedge sys_clk) disable iff (rst)
      !sel_valid |=> !host_data_oe && $stable(in_v[0]) && $stable(in_v[1]) && $stable(in_v[2]))
      else $error("bus not ignored while no port selected");
   a_read_status_sel: assert property (@(posedge sys_clk) disable iff (rst)
      rd_go && host_addr_bit_zero |=> host_data_out == $past(stat_v[sel]) && host_data_oe)
      else $error("host status read returned wrong byte");
   a_kbd_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
      wr_go && port_hit[0] |=> kbd_buf_irq == kbd_buf_irq_en)
      else $error("keyboard core interrupt not following enable after host write");
   a_host_irq_pins: assert property (@(posedge sys_clk) disable iff (rst)
      sfr_wr && sfr_addr == HMP_OUT_ADDR[1] |=> host_power_one_irq_n == 1'b0)
      else $error("power one host interrupt not raised");
   a_out_clear_read: assert property (@(posedge sys_clk) disable iff (rst)
      rd_go && port_hit[0] && !host_addr_bit_zero && !(sfr_wr && mc_out_hit[0])
      |=> !host_kbd_irq_pin)
      else $error("keyboard output full not cleared by host read");
   a_in_write_dropped: assert property (@(posedge sys_clk) disable iff (rst)
      sfr_wr && mc_in_hit[0] && !(wr_go && port_hit[0]) |=> $stable(in_v[0]))
      else $error("core write changed input byte");

endmodule
`default_nettype wire

// file: hmp_host_model.sv
// host cpu model driving the mailbox ports as a pc-style i/o bus master
`timescale 1ns/10ps
`default_nettype none
module hmp_host_model
   import hmp_pkg::*;
(
   input  wire logic              sys_clk,                 // bus is synchronous to the core clock
   input  wire logic [HMP_DW-1:0] host_data_out,           // byte returned by the device
   input  wire logic              host_data_oe,            // device drives the bus
   output logic                   kbd_port_select_n,       // keyboard port select
   output logic                   power_port_one_select_n, // power port one select
   output logic                   power_port_two_select_n, // power port two select
   output logic                   host_addr_bit_zero,      // data versus command or status
   output logic                   host_rd_n,               // read strobe
   output logic                   host_wr_n,               // write strobe
   output logic [HMP_DW-1:0]      host_data_in             // write byte
);
   int slow = 0;  // extra cycles a strobe is held, to act as a slow host

   // ---------------------------------------------------------------
   // idle bus at time zero
   // ---------------------------------------------------------------
   initial begin
      {kbd_port_select_n, power_port_one_select_n, power_port_two_select_n} = 3'h7;
      {host_addr_bit_zero, host_rd_n, host_wr_n} = 3'h7;
      host_data_in = 8'h00;
   end

   // ---------------------------------------------------------------
   // bus cycles
   // ---------------------------------------------------------------
   // at most one select low; port 3 means none selected
   task automatic put_sel(input int p);
      kbd_port_select_n <= (p != 0);
      power_port_one_select_n <= (p != 1);
      power_port_two_select_n <= (p != 2);
   endtask

   // write strobe; released lines never keep the old byte
   task automatic host_write(input int p, input logic a0, input logic [7:0] d);
      @(posedge sys_clk);
      put_sel(p);
      host_addr_bit_zero <= a0;
      host_data_in <= d;
      host_wr_n <= 1'b0;
      repeat (1 + slow) @(posedge sys_clk);
      host_wr_n <= 1'b1;
      put_sel(3);
      host_data_in <= ~d;
      @(posedge sys_clk);
   endtask

   // read strobe held until the answer has had time to stand
   task automatic host_read(input int p, input logic a0, output logic [7:0] d, output logic oe);
      @(posedge sys_clk);
      put_sel(p);
      host_addr_bit_zero <= a0;
      host_rd_n <= 1'b0;
      repeat (2 + slow) @(posedge sys_clk);
      d = host_data_out;
      oe = host_data_oe;
      host_rd_n <= 1'b1;
      put_sel(3);
      @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// file: hmp_top_tb.sv
// self-checking bench for the three host mailbox ports
`timescale 1ns/10ps
`default_nettype none
module hmp_top_tb;
   import hmp_pkg::*;
   // ---------------------------------------------------------------
   // stimulus, wires and reference model
   // ---------------------------------------------------------------
   logic       sys_clk = 1'b0;   // 40 MHz core clock
   logic       rst = 1'b1;       // synchronous reset
   logic [7:0] sfr_addr = 8'h00; // core register address
   logic       sfr_wr = 1'b0;
   logic       sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [2:0] irq_en = 3'h0;    // core interrupt enables
   wire  [7:0] sfr_rdata, host_data_out, host_data_in;
   wire        oe_w, kbd_pin, pm1_n, pm2_n, sk_n, s1_n, s2_n, a0_w, rd_n, wr_n;
   wire  [2:0] irq;              // core interrupt requests
   int         err_total = 0;
   int         check_count = 0;
   int         seed = 32'h153A01B0;
   logic [7:0] m_in[3], m_out[3], m_user[3], v, d;  // model bytes
   logic       m_cmd[3], m_ibf[3], m_obf[3], oe;    // model flags

   always #12.5 sys_clk = ~sys_clk;

   hmp_top i_dut (.sys_clk(sys_clk), .rst(rst), .kbd_port_select_n(sk_n),
      .power_port_one_select_n(s1_n), .power_port_two_select_n(s2_n),
      .host_addr_bit_zero(a0_w), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_data_in(host_data_in),
      .host_data_out(host_data_out), .host_data_oe(oe_w), .host_kbd_irq_pin(kbd_pin),
      .host_power_one_irq_n(pm1_n), .host_power_two_irq_n(pm2_n), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .kbd_buf_irq_en(irq_en[0]), .power_one_buf_irq_en(irq_en[1]),
      .power_two_buf_irq_en(irq_en[2]), .kbd_buf_irq(irq[0]), .power_one_buf_irq(irq[1]),
      .power_two_buf_irq(irq[2]));

   hmp_host_model i_host (.sys_clk(sys_clk), .host_data_out(host_data_out),
      .host_data_oe(oe_w), .kbd_port_select_n(sk_n), .power_port_one_select_n(s1_n),
      .power_port_two_select_n(s2_n), .host_addr_bit_zero(a0_w), .host_rd_n(rd_n),
      .host_wr_n(wr_n), .host_data_in(host_data_in));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // expected status byte from the model
   function automatic logic [7:0] exp_stat(input int p);
      return m_user[p] | {4'h0, m_cmd[p], 1'b0, m_ibf[p], m_obf[p]};
   endfunction

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] b);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_wdata <= b;
      sfr_wr <= 1'b1;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask

   // read data holds until the next read, so sampling late is safe
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] b);
      @(posedge sys_clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge sys_clk);
      sfr_rd <= 1'b0;
      repeat (2) @(posedge sys_clk);
      b = sfr_rdata;
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      sfr_read(a, r);
      check(nm, r, e);
   endtask

   // let flag updates land, then compare both interrupt sides
   task automatic chk_irq;
      repeat (2) @(negedge sys_clk);
      check("host_irq", {5'h00, pm2_n, pm1_n, kbd_pin}, {5'h00, ~m_obf[2], ~m_obf[1], m_obf[0]});
      check("core_irq", {5'h00, irq}, {5'h00, irq_en & {m_ibf[2], m_ibf[1], m_ibf[0]}});
   endtask

   // ---------------------------------------------------------------
   // watchdog: the whole run needs well under 4000 cycles
   // ---------------------------------------------------------------
   initial begin
      #(25 * 4000);
      err_total++;
      test_done;
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      // flags clear after reset; user bits writable, input/output-full bits refused
      for (int p = 0; p < 3; p++) begin
         m_ibf[p] = 1'b0;
         m_obf[p] = 1'b0;
         sfr_read(HMP_STAT_ADDR[p], v);
         check("stat_flags", v & 8'h03, 8'h00);
         d = $random(seed);
         sfr_write(HMP_STAT_ADDR[p], d | 8'h0B);
         m_user[p] = d & HMP_USER_MASK;
         sfr_read(HMP_STAT_ADDR[p], v);
         check("stat_user", v & 8'hF7, m_user[p]);
      end
      $display("test status_bits done");
      // host data and command writes, core reads input byte
      for (int p = 0; p < 3; p++) begin
         for (int a = 0; a < 2; a++) begin
            @(posedge sys_clk);
            irq_en <= (a == 1) ? 3'h7 : 3'($random(seed));
            sfr_read(HMP_STAT_ADDR[p], v);
            check("in_full_idle", v & 8'h02, 8'h00);
            d = $random(seed);
            i_host.host_write(p, a[0], d);
            m_in[p] = d;
            m_cmd[p] = a[0];
            m_ibf[p] = 1'b1;
            chk_irq;
            rd_chk("status", HMP_STAT_ADDR[p], exp_stat(p));
            sfr_write(HMP_IN_ADDR[p], ~d);
            rd_chk("in_data", HMP_IN_ADDR[p], d);
            m_ibf[p] = 1'b0;
            chk_irq;
            rd_chk("status_rd", HMP_STAT_ADDR[p], exp_stat(p));
         end
      end
      $display("test host_write done");
      // core fills output byte, host polls status then reads data
      for (int p = 0; p < 3; p++) begin
         i_host.slow = p;
         d = $random(seed);
         sfr_write(HMP_OUT_ADDR[p], d);
         m_out[p] = d;
         m_obf[p] = 1'b1;
         chk_irq;
         i_host.host_read(p, 1'b1, v, oe);
         check("host_status", v, exp_stat(p));
         i_host.host_read(p, 1'b0, v, oe);
         check("host_data", v, d);
         check("host_oe", {7'h00, oe}, 8'h01);
         m_obf[p] = 1'b0;
         chk_irq;
         rd_chk("out_data", HMP_OUT_ADDR[p], d);
      end
      i_host.slow = 0;
      $display("test host_read done");
      // no port selected: bus ignored
      i_host.host_write(3, 1'b1, 8'h5A);
      i_host.host_read(3, 1'b0, v, oe);
      check("idle_oe", {7'h00, oe}, 8'h00);
      for (int p = 0; p < 3; p++)
         rd_chk("idle_stat", HMP_STAT_ADDR[p], exp_stat(p));
      rd_chk("unmapped", 8'h00, HMP_RD_IDLE);
      $display("test no_select done");
      // reset in mid-run with both flags set
      d = $random(seed);
      i_host.host_write(2, ~m_cmd[2], d);
      m_in[2] = d;
      m_cmd[2] = ~m_cmd[2];
      sfr_write(HMP_OUT_ADDR[0], ~d);
      m_out[0] = ~d;
      m_ibf[2] = 1'b1;
      m_obf[0] = 1'b1;
      chk_irq;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      m_ibf[2] = 1'b0;
      m_obf[0] = 1'b0;
      chk_irq;
      for (int p = 0; p < 3; p++) begin
         rd_chk("rst_stat", HMP_STAT_ADDR[p], exp_stat(p));
         rd_chk("rst_in", HMP_IN_ADDR[p], m_in[p]);
         rd_chk("rst_out", HMP_OUT_ADDR[p], m_out[p]);
      end
      $display("test mid_reset done");
      test_done;
   end
endmodule
`default_nettype wire
